// *** hdl/tccc_pkg.sv ***
package tccc_pkg;

    localparam int ADDR_W = 8;

    localparam logic [7:0] ADDR_COUNT  = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_VALUE  = 8'h08;
    localparam logic [7:0] ADDR_SETUP  = 8'h0C;
    localparam logic [7:0] ADDR_PERIOD = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_MASK   = 8'h18;

    localparam int EDGE_LSB   = 14;
    localparam int SRC_LSB    = 12;
    localparam int SYNC_BIT   = 11;
    localparam int LOAD_LSB   = 9;
    localparam int FUNC_BIT   = 8;
    localparam int WAVE_LSB   = 5;
    localparam int IRQEN_BIT  = 4;
    localparam int LEVEL_BIT  = 3;
    localparam int OUTBIT_BIT = 2;
    localparam int LOST_BIT   = 1;
    localparam int PEND_BIT   = 0;

    localparam int ST_CAPTURE = 0;
    localparam int ST_EQUAL   = 1;
    localparam int ST_LOST    = 2;
    localparam int ST_W       = 3;

    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] VALUE_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;

    localparam logic [1:0] SRC_A   = 2'h0;
    localparam logic [1:0] SRC_B   = 2'h1;
    localparam logic [1:0] SRC_GND = 2'h2;

    localparam logic [1:0] LOAD_ON_WRITE = 2'h0;
    localparam logic [1:0] LOAD_AT_ZERO  = 2'h1;
    localparam logic [1:0] LOAD_AT_ENDS  = 2'h2;

    localparam logic [2:0] WAVE_LEVEL      = 3'h0;
    localparam logic [2:0] WAVE_SET        = 3'h1;
    localparam logic [2:0] WAVE_TOG_RESET  = 3'h2;
    localparam logic [2:0] WAVE_SET_RESET  = 3'h3;
    localparam logic [2:0] WAVE_TOGGLE     = 3'h4;
    localparam logic [2:0] WAVE_RESET      = 3'h5;
    localparam logic [2:0] WAVE_TOG_SET    = 3'h6;
    localparam logic [2:0] WAVE_RESET_SET  = 3'h7;

    typedef enum logic [1:0] {
        TCCC_STOP,
        TCCC_UP,
        TCCC_CONTINUOUS,
        TCCC_UPDOWN
    } tccc_run_t;

endpackage : tccc_pkg

// *** hdl/tccc_capture_input.sv ***
`timescale 1ns/1ps
module tccc_capture_input (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       input_source_a,
    input  wire logic       input_source_b,
    input  wire logic [1:0] input_source_select,
    input  wire logic       sync_source_select,
    input  wire logic [1:0] edge_select,
    output logic            capture_event,
    output logic            sampled_level
);
    import tccc_pkg::*;

    logic sync_first;
    logic sync_second;
    logic sync_prev;
    logic raw_prev;

    wire selected_raw = (input_source_select == SRC_A)   ? input_source_a :
                        (input_source_select == SRC_B)   ? input_source_b :
                        (input_source_select == SRC_GND) ? 1'b0 : 1'b1;

    // direct path still needs one flop to see an edge; a source switch can fake one
    wire cur_level  = sync_source_select ? sync_second : selected_raw;
    wire prev_level = sync_source_select ? sync_prev : raw_prev;
    wire rising     = cur_level & ~prev_level;
    wire falling    = ~cur_level & prev_level;

    assign capture_event = (edge_select[0] & rising) | (edge_select[1] & falling);
    assign sampled_level = cur_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
            sync_prev   <= 1'b0;
            raw_prev    <= 1'b0;
        end else begin
            sync_first  <= selected_raw;
            sync_second <= sync_first;
            sync_prev   <= sync_second;
            raw_prev    <= selected_raw;
        end
    end

endmodule : tccc_capture_input

// *** hdl/tccc_waveform.sv ***
`timescale 1ns/1ps
module tccc_waveform (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] waveform_mode,
    input  wire logic       out_level_bit,
    input  wire logic       channel_equal_event,
    input  wire logic       period_equal_event,
    output logic            channel_out
);
    import tccc_pkg::*;

    logic next_out;

    // the period end acts after the channel match, so it wins when both coincide
    always_comb begin
        next_out = channel_out;
        unique case (waveform_mode)
            WAVE_LEVEL: begin
                next_out = out_level_bit;
            end
            WAVE_SET, WAVE_SET_RESET: begin
                if (channel_equal_event) next_out = 1'b1;
            end
            WAVE_TOG_RESET, WAVE_TOGGLE, WAVE_TOG_SET: begin
                if (channel_equal_event) next_out = ~channel_out;
            end
            WAVE_RESET, WAVE_RESET_SET: begin
                if (channel_equal_event) next_out = 1'b0;
            end
        endcase
        if (period_equal_event) begin
            if (waveform_mode == WAVE_TOG_RESET || waveform_mode == WAVE_SET_RESET) begin
                next_out = 1'b0;
            end
            if (waveform_mode == WAVE_TOG_SET || waveform_mode == WAVE_RESET_SET) begin
                next_out = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_out <= 1'b0;
        end else begin
            channel_out <= next_out;
        end
    end

endmodule : tccc_waveform

// *** hdl/tccc_channel.sv ***
// Notes on behaviour
// - timer count is a 16-bit read/write register, zero after reset.
// - edge select: 00 no capture, 01 rising, 10 falling, 11 both edges.
// - input select: source A, source B, ground, supply level.
// - sync select 1 synchronises the capture input; 0 captures directly.
// - load policy 00 on write, 01 at zero, 11 at count equal latch.
// - load policy 10: at zero; in up/down also at the period latch value.
// - in compare mode the data register holds the compare value.
// - capture mode copies the running count into the data register per event.
// - waveform mode selects level, set, toggle, reset and combined behaviours.
// - interrupt enable bit gates the pending flag onto the interrupt.
// - read-only bit shows the selected capture input level.
// - in mode 0 the output bit drives the output directly.
// - lost event flag set by capture overflow, cleared only by software zero.
// - pending flag reads 1 while an interrupt is pending; software writable.
`timescale 1ns/1ps
module tccc_channel #(
    parameter int CLK_DIV = 1
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [tccc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic                         input_source_a,
    input  wire logic                         input_source_b,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              irq,
    output logic                              channel_out
);
    import tccc_pkg::*;

    if (CLK_DIV < 1 || CLK_DIV > 65536) begin : g_bad_div
        $error("CLK_DIV must lie in 1..65536");
    end

    logic [15:0]     timer_count;
    logic            count_up;
    logic [15:0]     div_count;
    logic [1:0]      edge_select;
    logic [1:0]      input_source_select;
    logic            sync_source_select;
    logic [1:0]      shadow_load_policy;
    logic            channel_function_select;
    logic [2:0]      waveform_mode;
    logic            channel_irq_enable;
    logic            out_level_bit;
    logic            lost_event_flag;
    logic            channel_pending_flag;
    logic [15:0]     channel_capture_compare_value;
    logic [15:0]     compare_shadow_latch;
    logic [15:0]     period_shadow_latch;
    tccc_run_t       run_mode;
    logic [ST_W-1:0] irq_status;
    logic [ST_W-1:0] irq_mask;
    logic            capture_unread;
    logic [15:0]     next_count;
    logic            next_up;
    logic            capture_event;
    logic            sampled_input_level;

    // bus decode: zero wait states, answer in the first access cycle
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire wr_done     = access_done & pwrite;
    wire rd_done     = access_done & ~pwrite;

    wire hit_count  = paddr == ADDR_COUNT;
    wire hit_ctrl   = paddr == ADDR_CTRL;
    wire hit_value  = paddr == ADDR_VALUE;
    wire hit_setup  = paddr == ADDR_SETUP;
    wire hit_period = paddr == ADDR_PERIOD;
    wire hit_status = paddr == ADDR_STATUS;
    wire hit_mask   = paddr == ADDR_MASK;
    wire mapped     = hit_count | hit_ctrl | hit_value | hit_setup | hit_period | hit_status | hit_mask;

    wire wr_count  = wr_done & hit_count;
    wire wr_ctrl   = wr_done & hit_ctrl;
    wire wr_value  = wr_done & hit_value;
    wire wr_setup  = wr_done & hit_setup;
    wire wr_period = wr_done & hit_period;
    wire wr_status = wr_done & hit_status;
    wire wr_mask   = wr_done & hit_mask;
    wire rd_value  = rd_done & hit_value;

    wire [15:0] ctrl_word = {edge_select, input_source_select, sync_source_select,
                             shadow_load_policy, channel_function_select, waveform_mode,
                             channel_irq_enable, sampled_input_level, out_level_bit,
                             lost_event_flag, channel_pending_flag};

    wire [31:0] read_word = hit_count  ? {16'h0000, timer_count} :
                            hit_ctrl   ? {16'h0000, ctrl_word} :
                            hit_value  ? {16'h0000, channel_capture_compare_value} :
                            hit_setup  ? {30'h00000000, run_mode} :
                            hit_period ? {16'h0000, period_shadow_latch} :
                            hit_status ? {29'h00000000, irq_status} :
                            hit_mask   ? {29'h00000000, irq_mask} : 32'h00000000;

    // count advances on a divided enable; a count write overrides the step
    wire tick    = div_count == 16'(CLK_DIV - 1);
    wire running = tick & (run_mode != TCCC_STOP);

    always_comb begin
        next_count = timer_count;
        next_up    = count_up;
        if (running) begin
            unique case (run_mode)
                TCCC_UP: begin
                    next_count = (timer_count >= period_shadow_latch) ? 16'h0000 : timer_count + 16'h0001;
                end
                TCCC_CONTINUOUS: begin
                    next_count = timer_count + 16'h0001;
                end
                TCCC_UPDOWN: begin
                    if (period_shadow_latch == 16'h0000) begin
                        next_count = 16'h0000;
                    end else if (count_up && timer_count >= period_shadow_latch) begin
                        next_count = timer_count - 16'h0001;
                        next_up    = 1'b0;
                    end else if (!count_up && timer_count == 16'h0000) begin
                        next_count = 16'h0001;
                        next_up    = 1'b1;
                    end else begin
                        next_count = count_up ? timer_count + 16'h0001 : timer_count - 16'h0001;
                    end
                end
                default: begin
                    next_count = timer_count;
                end
            endcase
        end
        if (wr_count) begin
            next_count = pwdata[15:0];
        end
    end

    // events are judged on the count that stands at the enable
    wire zero_event          = running & (timer_count == 16'h0000);
    wire period_equal_event  = running & (timer_count == period_shadow_latch);
    wire latch_equal         = running & (timer_count == compare_shadow_latch);
    wire channel_equal_event = latch_equal & ~channel_function_select;
    wire capture_taken       = capture_event & channel_function_select;
    wire capture_lost        = capture_taken & capture_unread;

    wire load_latch = (shadow_load_policy == LOAD_ON_WRITE) ? wr_value :
                      (shadow_load_policy == LOAD_AT_ZERO)  ? zero_event :
                      (shadow_load_policy == LOAD_AT_ENDS)  ?
                          (zero_event | (period_equal_event & (run_mode == TCCC_UPDOWN))) :
                      latch_equal;

    wire [ST_W-1:0] status_events;
    assign status_events[ST_CAPTURE] = capture_taken;
    assign status_events[ST_EQUAL]   = channel_equal_event;
    assign status_events[ST_LOST]    = capture_lost;

    wire [ST_W-1:0] status_clear = wr_status ? pwdata[ST_W-1:0] : {ST_W{1'b0}};
    wire set_pending             = capture_taken | channel_equal_event;

    tccc_capture_input u_capture (
        .pclk                (pclk),
        .presetn             (presetn),
        .input_source_a      (input_source_a),
        .input_source_b      (input_source_b),
        .input_source_select (input_source_select),
        .sync_source_select  (sync_source_select),
        .edge_select         (edge_select),
        .capture_event       (capture_event),
        .sampled_level       (sampled_input_level)
    );

    tccc_waveform u_waveform (
        .pclk                (pclk),
        .presetn             (presetn),
        .waveform_mode       (waveform_mode),
        .out_level_bit       (out_level_bit),
        .channel_equal_event (channel_equal_event),
        .period_equal_event  (period_equal_event),
        .channel_out         (channel_out)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            prdata  <= setup_phase ? read_word : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count   <= 16'h0000;
            timer_count <= COUNT_RESET;
            count_up    <= 1'b1;
        end else begin
            div_count   <= tick ? 16'h0000 : div_count + 16'h0001;
            timer_count <= next_count;
            count_up    <= wr_setup ? 1'b1 : next_up;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_select             <= 2'h0;
            input_source_select     <= 2'h0;
            sync_source_select      <= 1'b0;
            shadow_load_policy      <= 2'h0;
            channel_function_select <= 1'b0;
            waveform_mode           <= 3'h0;
            channel_irq_enable      <= 1'b0;
            out_level_bit           <= 1'b0;
        end else if (wr_ctrl) begin
            edge_select             <= pwdata[EDGE_LSB+1:EDGE_LSB];
            input_source_select     <= pwdata[SRC_LSB+1:SRC_LSB];
            sync_source_select      <= pwdata[SYNC_BIT];
            shadow_load_policy      <= pwdata[LOAD_LSB+1:LOAD_LSB];
            channel_function_select <= pwdata[FUNC_BIT];
            waveform_mode           <= pwdata[WAVE_LSB+2:WAVE_LSB];
            channel_irq_enable      <= pwdata[IRQEN_BIT];
            out_level_bit           <= pwdata[OUTBIT_BIT];
        end
    end

    // flags: a hardware set in the same cycle as a software write wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_event_flag      <= 1'b0;
            channel_pending_flag <= 1'b0;
        end else begin
            if (capture_lost) begin
                lost_event_flag <= 1'b1;
            end else if (wr_ctrl) begin
                lost_event_flag <= pwdata[LOST_BIT];
            end
            if (set_pending) begin
                channel_pending_flag <= 1'b1;
            end else if (wr_ctrl) begin
                channel_pending_flag <= pwdata[PEND_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_capture_compare_value <= VALUE_RESET;
            compare_shadow_latch          <= VALUE_RESET;
            capture_unread                <= 1'b0;
        end else begin
            if (capture_taken) begin
                channel_capture_compare_value <= timer_count;
            end else if (wr_value) begin
                channel_capture_compare_value <= pwdata[15:0];
            end
            if (load_latch) begin
                // a value write in the same cycle supplies the written word, otherwise the stored one
                compare_shadow_latch <= wr_value ? pwdata[15:0] : channel_capture_compare_value;
            end
            if (capture_taken) begin
                capture_unread <= 1'b1;
            end else if (rd_value) begin
                capture_unread <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_mode            <= TCCC_STOP;
            period_shadow_latch <= PERIOD_RESET;
            irq_mask            <= {ST_W{1'b0}};
            irq_status          <= {ST_W{1'b0}};
            irq                 <= 1'b0;
        end else begin
            if (wr_setup) begin
                run_mode <= tccc_run_t'(pwdata[1:0]);
            end
            if (wr_period) begin
                period_shadow_latch <= pwdata[15:0];
            end
            if (wr_mask) begin
                irq_mask <= pwdata[ST_W-1:0];
            end
            irq_status <= (irq_status & ~status_clear) | status_events;
            irq        <= (|(irq_status & irq_mask)) | (channel_pending_flag & channel_irq_enable);
        end
    end

endmodule : tccc_channel

// *** test/tccc_channel_chk.sv ***
`timescale 1ns/1ps
module tccc_channel_chk
    import tccc_pkg::*;
#(
    parameter int CLK_DIV = 1
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              input_source_a,
    input wire logic              input_source_b,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              irq,
    input wire logic              channel_out
);
    logic lvl_q;
    wire  ctrl_rd = pready && !pwrite && paddr == ADDR_CTRL;
    wire  ctrl_wr = psel && penable && pready && pwrite && paddr == ADDR_CTRL;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // remembers the level bit of the last control write for the mode 0 check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lvl_q <= 1'b0;
        else if (ctrl_wr) lvl_q <= pwdata[OUTBIT_BIT];
    end

    AST_SETUP_READY: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside access");
    AST_UNMAPPED: assert property (psel && !penable && paddr > ADDR_MASK |=> pslverr && prdata == 32'h0)
        else $error("unmapped address accepted");
    AST_COUNT_UPPER: assert property (pready && !pwrite && paddr == ADDR_COUNT |-> prdata[31:16] == 16'h0)
        else $error("count upper bits not zero");
    AST_GND_LEVEL: assert property (ctrl_rd && prdata[SRC_LSB+:2] == SRC_GND |-> !prdata[LEVEL_BIT])
        else $error("ground source reads high");
    AST_VCC_LEVEL: assert property (ctrl_rd && prdata[SRC_LSB+:2] == 2'h3 |-> prdata[LEVEL_BIT])
        else $error("supply source reads low");
    AST_PEND_IRQ: assert property (ctrl_rd && prdata[PEND_BIT] && prdata[IRQEN_BIT] |-> ##[0:2] irq)
        else $error("enabled pending flag gives no interrupt");
    AST_LEVEL_OUT: assert property (ctrl_wr && pwdata[WAVE_LSB+:3] == WAVE_LEVEL |-> ##2 channel_out == lvl_q)
        else $error("mode 0 output differs from level bit");
endmodule : tccc_channel_chk

bind tccc_channel tccc_channel_chk #(.CLK_DIV(CLK_DIV)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .input_source_a(input_source_a), .input_source_b(input_source_b),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .channel_out(channel_out));

// *** test/tccc_src_model.sv ***
`timescale 1ns/1ps
module tccc_src_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow,
    input  wire logic want_a,
    input  wire logic want_b,
    output logic      input_source_a,
    output logic      input_source_b
);
    logic [1:0] stage;
    // slow sources sit behind an extra register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage <= 2'h0;
            input_source_a <= 1'b0;
            input_source_b <= 1'b0;
        end else begin
            stage <= {want_b, want_a};
            input_source_a <= slow ? stage[0] : want_a;
            input_source_b <= slow ? stage[1] : want_b;
        end
    end
endmodule : tccc_src_model

// *** test/test_timer_capture_compare_channel.sv ***
`timescale 1ns/1ps
module test_timer_capture_compare_channel;
    import tccc_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, channel_out;
    logic              want_a, want_b, slow, err, input_source_a, input_source_b;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rv, cw;
    logic [15:0]       v0, v1, v2;
    logic [1:0]        e;
    int                n_fail, cmp_count, seed;
    int                modes [4] = '{1, 5, 4, 4};
    logic              expo  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    tccc_channel #(.CLK_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .input_source_a(input_source_a),
        .input_source_b(input_source_b), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .channel_out(channel_out));
    tccc_src_model src (.pclk(pclk), .presetn(presetn), .slow(slow), .want_a(want_a), .want_b(want_b),
        .input_source_a(input_source_a), .input_source_b(input_source_b));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function automatic logic lvl(input logic [1:0] s);
        return s == SRC_A ? want_a : s == SRC_B ? want_b : s[0];
    endfunction : lvl

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rv = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
        if (n >= 16) begin
            n_fail++;
            end_of_test();
        end
    endtask : apb

    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle

    initial begin
        seed = 32'hDFF0E45A;
        {n_fail, cmp_count} = '0;
        {presetn, psel, penable, pwrite, want_a, want_b, slow, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, ADDR_COUNT, 0);
        chk("count_reset", 32'h0, rv);
        apb(0, ADDR_CTRL, 0);
        chk("ctrl_reset", 32'h0, rv & ~(32'h1 << LEVEL_BIT));
        apb(0, 8'h1C, 0);
        chk("unmapped", 32'h1, {31'h0, err});
        for (int i = 0; i < 4; i++) begin
            cw = (i == 0) ? 32'hFFFFFFFF : $random(seed);
            apb(1, ADDR_COUNT, cw);
            apb(0, ADDR_COUNT, 0);
            chk("count_rw", {16'h0, cw[15:0]}, rv);
        end
        for (int s = 0; s < 4; s++) begin
            {want_a, want_b, slow} <= 3'($random(seed));
            apb(1, ADDR_CTRL, 32'(s) << SRC_LSB);
            idle(5);
            apb(0, ADDR_CTRL, 0);
            chk("input_level", {31'h0, lvl(2'(s))}, {31'h0, rv[LEVEL_BIT]});
        end
        for (int k = 0; k < 4; k++) begin
            e = 2'(k);
            {v0, v1} = $random(seed);
            v2 = 16'($random(seed));
            cw = {16'h0, e, 2'b00, 1'($random(seed)), 2'b00, 1'b1, 3'b000, 1'b1, 4'h0};
            want_a <= 1'b0;
            apb(1, ADDR_CTRL, cw);
            idle(6);
            // source change may leave a stray capture: clear flags and mark it read
            apb(1, ADDR_CTRL, cw);
            apb(1, ADDR_STATUS, 32'h7);
            apb(1, ADDR_VALUE, {16'h0, v0});
            apb(0, ADDR_VALUE, 0);
            chk("value_wr", {16'h0, v0}, rv);
            apb(1, ADDR_COUNT, {16'h0, v1});
            want_a <= 1'b1;
            idle(6);
            apb(0, ADDR_VALUE, 0);
            chk("capture_rise", {16'h0, e[0] ? v1 : v0}, rv);
            apb(1, ADDR_COUNT, {16'h0, v2});
            want_a <= 1'b0;
            idle(6);
            apb(0, ADDR_VALUE, 0);
            chk("capture_fall", {16'h0, e[1] ? v2 : e[0] ? v1 : v0}, rv);
            want_a <= 1'b1;
            idle(6);
            want_a <= 1'b0;
            idle(6);
            apb(0, ADDR_CTRL, 0);
            chk("lost_pend", {30'h0, e == 2'h3, e != 2'h0}, rv & 32'h3);
            apb(1, ADDR_CTRL, cw);
            apb(0, ADDR_CTRL, 0);
            chk("lost_clear", 32'h0, rv & 32'h3);
            apb(1, ADDR_MASK, 32'h7);
            idle(2);
            chk("irq_mask", {31'h0, e != 2'h0}, {31'h0, irq});
            apb(1, ADDR_STATUS, 32'h7);
            apb(1, ADDR_MASK, 32'h0);
            idle(2);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
        for (int b = 1; b >= 0; b--) begin
            apb(1, ADDR_CTRL, 32'(b) << OUTBIT_BIT);
            idle(2);
            chk("level_out", 32'(b), {31'h0, channel_out});
        end
        apb(1, ADDR_VALUE, 32'h14);
        apb(1, ADDR_SETUP, 32'h2);
        for (int i = 0; i < 4; i++) begin
            apb(1, ADDR_CTRL, (32'(modes[i]) << WAVE_LSB) | 32'h10);
            apb(1, ADDR_COUNT, 32'h0);
            idle(40);
            chk("wave_out", {31'h0, expo[i]}, {31'h0, channel_out});
            apb(0, ADDR_CTRL, 0);
            chk("equal_pend", 32'h1, rv & 32'h1);
        end
        // up mode with period 0x30 and match at 0x14: set at the match, reset at period end
        apb(1, ADDR_SETUP, 32'h0);
        apb(1, ADDR_PERIOD, 32'h30);
        apb(1, ADDR_CTRL, 32'(WAVE_SET_RESET) << WAVE_LSB);
        apb(1, ADDR_SETUP, 32'h1);
        apb(1, ADDR_COUNT, 32'h0);
        idle(25);
        chk("set_reset_hi", 32'h1, {31'h0, channel_out});
        idle(30);
        chk("set_reset_lo", 32'h0, {31'h0, channel_out});
        apb(1, ADDR_SETUP, 32'h0);
        end_of_test();
    end
endmodule : test_timer_capture_compare_channel
